/* File: cam_cfg.svh */
/*
  register offsets, field positions and reset values of the counter array.
  assumes an apb slave with 32-bit words; each register one aligned word.
*/
`ifndef CAM_CFG_SVH
`define CAM_CFG_SVH
`define CAM_OFS_CTRL 12'h000
`define CAM_OFS_CNT_LO 12'h004
`define CAM_OFS_CNT_HI 12'h008
`define CAM_OFS_MODE0 12'h010
`define CAM_OFS_VLO0 12'h030
`define CAM_OFS_VHI0 12'h050
`define CAM_OFS_STRIDE 12'h004
`define CAM_MODE_RST 8'h00
`define CAM_BIT_CMP 6
`define CAM_BIT_RISE 5
`define CAM_BIT_FALL 4
`define CAM_BIT_HIT 3
`define CAM_BIT_FLIP 2
`define CAM_BIT_PWM 1
`define CAM_BIT_IRQ 0
`define CAM_CTRL_RUN 7
`define CAM_CTRL_GUARD 6
`define CAM_WDOG_MOD 4
`endif

/* File: cam_pkg.sv */
/*
  types of the counter array modules.
  assumes cam_cfg.svh supplies the numbers.
*/
package cam_pkg;
  typedef struct packed {
    logic cmp_en;
    logic rise_en;
    logic fall_en;
    logic hit_en;
    logic flip_en;
    logic pwm_en;
    logic irq_en;
  } cam_mode_s;
  typedef enum logic [1:0] {CAM_IDLE, CAM_ACCESS} cam_apb_e;
endpackage : cam_pkg

/* File: cam_counter_array.sv */
/*
  five capture/compare/pwm modules on one shared 16-bit counter, apb slave.
  assumes i_cnt_tick is a one-cycle enable from a divider on the same clock
  and module pins arrive asynchronously.
*/
`timescale 1ns/1ps
`include "cam_cfg.svh"
module cam_counter_array #(
  parameter int NMOD = 5
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cnt_tick,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NMOD-1:0] i_module_io_pin,
  output logic [NMOD-1:0] o_module_io_pin,
  output logic [NMOD-1:0] o_module_io_pin_oe_n,
  output logic o_irq,
  output logic o_internal_reset
);
  cam_pkg::cam_mode_s mode_q [NMOD], mode_d [NMOD];
  logic [7:0] vlo_q [NMOD], vlo_d [NMOD];
  logic [7:0] vhi_q [NMOD], vhi_d [NMOD];
  logic [NMOD-1:0] flag_q, flag_d, pin_q, pin_d;
  logic [NMOD-1:0] sync1_q, sync2_q, prev_q;
  logic [15:0] cnt_q, cnt_d;
  logic run_q, run_d, guard_q, guard_d;
  logic [31:0] rdata_q, rdata_d;
  logic slverr_q, slverr_d, rst_q, rst_d;
  cam_pkg::cam_apb_e st_q, st_d;
  logic wr, rd;
  logic [NMOD-1:0] hit, ev;

  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && i_penable && !i_pwrite;

  // zero-wait slave: access phase completes in its first cycle
  always_comb begin
    st_d = st_q;
    case (st_q)
      cam_pkg::CAM_IDLE: if (i_psel && !i_penable) st_d = cam_pkg::CAM_ACCESS;
      cam_pkg::CAM_ACCESS: st_d = cam_pkg::CAM_IDLE;
      default: st_d = cam_pkg::CAM_IDLE;
    endcase
  end
  assign o_pready = 1'b1;
  assign o_prdata = rdata_q;
  assign o_pslverr = slverr_q;

  genvar g;
  generate
    for (g = 0; g < NMOD; g++) begin : g_mod
      logic rise, fall, cap, eq, cmp_ok;
      logic [11:0] a_mode, a_vlo, a_vhi;
      assign a_mode = `CAM_OFS_MODE0 + 12'(g) * `CAM_OFS_STRIDE;
      assign a_vlo = `CAM_OFS_VLO0 + 12'(g) * `CAM_OFS_STRIDE;
      assign a_vhi = `CAM_OFS_VHI0 + 12'(g) * `CAM_OFS_STRIDE;
      assign rise = sync2_q[g] && !prev_q[g];
      assign fall = !sync2_q[g] && prev_q[g];
      assign cap = (mode_q[g].rise_en && rise) ||
                   (mode_q[g].fall_en && fall);
      assign eq = cnt_q == {vhi_q[g], vlo_q[g]};
      assign cmp_ok = mode_q[g].cmp_en && mode_q[g].hit_en && !mode_q[g].pwm_en;
      assign hit[g] = cmp_ok && eq && i_cnt_tick && run_q;
      assign ev[g] = cap || hit[g];

      always_comb begin
        mode_d[g] = mode_q[g];
        vlo_d[g] = vlo_q[g];
        vhi_d[g] = vhi_q[g];
        pin_d[g] = pin_q[g];
        if (wr && i_paddr == a_mode)
          mode_d[g] = cam_pkg::cam_mode_s'(i_pwdata[6:0]);
        if (wr && i_paddr == a_vlo) begin
          vlo_d[g] = i_pwdata[7:0];
          mode_d[g].cmp_en = 1'b0;
        end
        if (wr && i_paddr == a_vhi) begin
          vhi_d[g] = i_pwdata[7:0];
          mode_d[g].cmp_en = 1'b1;
        end
        if (cap) begin
          vlo_d[g] = cnt_q[7:0];
          vhi_d[g] = cnt_q[15:8];
        end
        if (mode_q[g].pwm_en && mode_q[g].cmp_en) begin
          // pin follows comparison of shared low byte, so one frequency
          pin_d[g] = cnt_q[7:0] >= vlo_q[g];
          // reload only at wrap so duty changes mid-period only on a vlo write or a capture
          if (i_cnt_tick && run_q && cnt_q[7:0] == 8'hff)
            vlo_d[g] = vhi_q[g];
        end else if (hit[g] && mode_q[g].flip_en) begin
          pin_d[g] = !pin_q[g];
        end
      end

      always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
          mode_q[g] <= cam_pkg::cam_mode_s'(`CAM_MODE_RST);
          vlo_q[g] <= 8'h00;
          vhi_q[g] <= 8'h00;
        end else begin
          mode_q[g] <= mode_d[g];
          vlo_q[g] <= vlo_d[g];
          vhi_q[g] <= vhi_d[g];
        end
      end
    end
  endgenerate

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    guard_d = guard_q;
    flag_d = flag_q;
    rst_d = 1'b0;
    if (wr && i_paddr == `CAM_OFS_CTRL) begin
      run_d = i_pwdata[`CAM_CTRL_RUN];
      guard_d = i_pwdata[`CAM_CTRL_GUARD];
      flag_d = flag_q & i_pwdata[NMOD-1:0]; // write zero clears
    end
    flag_d = flag_d | ev;
    if (i_cnt_tick && run_q)
      cnt_d = cnt_q + 16'h0001;
    if (wr && i_paddr == `CAM_OFS_CNT_LO)
      cnt_d[7:0] = i_pwdata[7:0];
    if (wr && i_paddr == `CAM_OFS_CNT_HI)
      cnt_d[15:8] = i_pwdata[7:0];
    // watchdog is module 4 only; drives internal reset, and toggles pin 4 too if its flip_en is set
    if (guard_q && hit[`CAM_WDOG_MOD]) rst_d = 1'b1;
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    slverr_d = 1'b0;
    if (i_psel && !i_penable) begin
      if (i_paddr == `CAM_OFS_CTRL)
        rdata_d = {24'h0, run_q, guard_q, 1'b0, flag_q};
      else if (i_paddr == `CAM_OFS_CNT_LO) rdata_d = {24'h0, cnt_q[7:0]};
      else if (i_paddr == `CAM_OFS_CNT_HI) rdata_d = {24'h0, cnt_q[15:8]};
      else slverr_d = 1'b1;
      for (int k = 0; k < NMOD; k++) begin
        if (i_paddr == `CAM_OFS_MODE0 + 12'(k) * `CAM_OFS_STRIDE) begin
          rdata_d = {25'h0, mode_q[k]};
          slverr_d = 1'b0;
        end
        if (i_paddr == `CAM_OFS_VLO0 + 12'(k) * `CAM_OFS_STRIDE) begin
          rdata_d = {24'h0, vlo_q[k]};
          slverr_d = 1'b0;
        end
        if (i_paddr == `CAM_OFS_VHI0 + 12'(k) * `CAM_OFS_STRIDE) begin
          rdata_d = {24'h0, vhi_q[k]};
          slverr_d = 1'b0;
        end
      end
    end else if (st_q == cam_pkg::CAM_ACCESS) begin
      rdata_d = rdata_q;
      slverr_d = slverr_q;
    end
  end

  always_comb begin
    o_irq = 1'b0;
    for (int k = 0; k < NMOD; k++)
      if (flag_q[k] && mode_q[k].irq_en) o_irq = 1'b1;
  end

  assign o_module_io_pin = pin_q;
  assign o_module_io_pin_oe_n = ~{NMOD{1'b0}} ^ pin_drv(mode_q);
  assign o_internal_reset = rst_q;

  function automatic logic [NMOD-1:0] pin_drv(input cam_pkg::cam_mode_s m [NMOD]);
    logic [NMOD-1:0] r;
    r = '0;
    for (int k = 0; k < NMOD; k++)
      r[k] = m[k].flip_en || (m[k].pwm_en && m[k].cmp_en);
    return r;
  endfunction : pin_drv

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      guard_q <= 1'b0;
      flag_q <= '0;
      pin_q <= '0;
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
      rst_q <= 1'b0;
      st_q <= cam_pkg::CAM_IDLE;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      guard_q <= guard_d;
      flag_q <= flag_d;
      pin_q <= pin_d;
      sync1_q <= i_module_io_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
      rst_q <= rst_d;
      st_q <= st_d;
    end
  end
endmodule : cam_counter_array

/* File: cam_pin_model.sv */
/* far side of the module pins: resolves each pin wire.
   assumes the bench sets i_drv and oe_n low means the block drives. */
`timescale 1ns/1ps
module cam_pin_model (
  input wire logic [4:0] i_drv,
  input wire logic [4:0] i_out,
  input wire logic [4:0] i_oe_n,
  output logic [4:0] o_pin
);
  // a driven pin follows the block, an undriven one the far side
  always_comb o_pin = (i_out & ~i_oe_n) | (i_drv & i_oe_n);
endmodule : cam_pin_model

/* File: cam_counter_array_sva.sv */
/* port checker of the counter array.
   assumes it is bound to cam_counter_array. */
`timescale 1ns/1ps
module cam_chk #(
  parameter int NMOD = 5
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cnt_tick,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [NMOD-1:0] o_module_io_pin_oe_n,
  input wire logic o_irq,
  input wire logic o_internal_reset
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic acc;
  logic bad;
  assign acc = i_psel && i_penable;
  assign bad = i_paddr[11:7] != 5'h00;
  property p_rdy; acc |-> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_err; acc && bad |-> o_pslverr; endproperty
  a_err: assert property (p_err) else $error("no slverr");
  property p_ok; acc && i_paddr == 12'h000 |-> !o_pslverr; endproperty
  a_ok: assert property (p_ok) else $error("false slverr");
  property p_rd0; acc && bad && !i_pwrite |-> o_prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped data");
  property p_oe; $changed(o_module_io_pin_oe_n) |-> $past(acc && i_pwrite);
  endproperty
  a_oe: assert property (p_oe) else $error("oe moved alone");
  property p_irq; $fell(o_irq) |-> $past(acc && i_pwrite); endproperty
  a_irq: assert property (p_irq) else $error("flag lost");
  property p_wdt; o_internal_reset |-> $past(i_cnt_tick); endproperty
  a_wdt: assert property (p_wdt) else $error("reset w/o tick");
  property p_wdp; o_internal_reset |=> !o_internal_reset; endproperty
  a_wdp: assert property (p_wdp) else $error("reset too long");
  c_wd: cover property (o_internal_reset);
  c_irq: cover property ($rose(o_irq));
  c_err: cover property (acc && bad);
endmodule : cam_chk
bind cam_counter_array cam_chk #(.NMOD(NMOD)) u_chk (.i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn), .i_cnt_tick(i_cnt_tick), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_module_io_pin_oe_n(o_module_io_pin_oe_n), .o_irq(o_irq),
  .o_internal_reset(o_internal_reset));

/* File: tb.sv */
/* self-checking bench of the counter array.
   assumes the pin model and the bound checker are compiled. */
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, r;
  logic [4:0] drv = 5'h00, pin, po, oe;
  logic rdy, serr, se, irq, irst;
  int err_count = 0, checks = 0, nrst = 0;
  cam_counter_array uut (.i_clk_sys(clk), .i_rstn(rst_n), .i_cnt_tick(tick),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr),
    .i_module_io_pin(pin), .o_module_io_pin(po),
    .o_module_io_pin_oe_n(oe), .o_irq(irq), .o_internal_reset(irst));
  cam_pin_model pm (.i_drv(drv), .i_out(po), .i_oe_n(oe), .o_pin(pin));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (irst) nrst <= nrst + 1;
  task ck(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    r = prd;
    se = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    ck(r[7:0], e);
  endtask : rd
  task tk(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask : tk
  task t_reset;
    for (int n = 0; n < 5; n++) rd(12'h010 + 12'(4 * n), 8'h00);
  endtask : t_reset
  task t_cmp;
    apb(1'h1, 12'h010, 8'h40);
    rd(12'h010, 8'h40);
    apb(1'h1, 12'h030, 8'h12);
    rd(12'h010, 8'h00);
    apb(1'h1, 12'h050, 8'h34);
    rd(12'h010, 8'h40);
  endtask : t_cmp
  task t_tog;
    apb(1'h1, 12'h014, 8'h0d);
    apb(1'h1, 12'h034, 8'h05);
    apb(1'h1, 12'h054, 8'h00);
    apb(1'h1, 12'h004, 8'h03);
    apb(1'h1, 12'h000, 8'h80);
    tk(4);
    apb(1'h1, 12'h000, 8'h1f);
    ck(pin[1], 1'h1);
    ck(irq, 1'h1);
    rd(12'h000, 8'h02);
    apb(1'h1, 12'h000, 8'h00);
    @(posedge clk);
    ck(irq, 1'h0);
  endtask : t_tog
  task t_cap;
    apb(1'h1, 12'h008, 8'h12);
    apb(1'h1, 12'h004, 8'h34);
    apb(1'h1, 12'h018, 8'h20);
    drv[2] <= 1'b1;
    repeat (6) @(posedge clk);
    rd(12'h038, 8'h34);
    rd(12'h058, 8'h12);
    apb(1'h1, 12'h004, 8'h56);
    drv[2] <= 1'b0;
    repeat (6) @(posedge clk);
    rd(12'h038, 8'h34);
    rd(12'h000, 8'h04);
  endtask : t_cap
  task t_pwm;
    apb(1'h1, 12'h03c, 8'h80);
    apb(1'h1, 12'h05c, 8'h10);
    apb(1'h1, 12'h01c, 8'h02);
    @(posedge clk);
    ck(oe[3], 1'h1);
    apb(1'h1, 12'h004, 8'h7f);
    apb(1'h1, 12'h01c, 8'h42);
    repeat (3) @(posedge clk);
    ck(pin[3], 1'h0);
    ck(oe[3], 1'h0);
    apb(1'h1, 12'h004, 8'h80);
    repeat (3) @(posedge clk);
    ck(pin[3], 1'h1);
    apb(1'h1, 12'h004, 8'hff);
    apb(1'h1, 12'h000, 8'h80);
    tk(1);
    apb(1'h1, 12'h000, 8'h00);
    apb(1'h1, 12'h004, 8'h20);
    repeat (3) @(posedge clk);
    ck(pin[3], 1'h1);
  endtask : t_pwm
  task t_wdog;
    apb(1'h1, 12'h040, 8'h01);
    apb(1'h1, 12'h060, 8'h01);
    apb(1'h1, 12'h020, 8'h48);
    apb(1'h1, 12'h008, 8'h01);
    apb(1'h1, 12'h004, 8'h00);
    apb(1'h1, 12'h000, 8'h80);
    tk(3);
    ck(nrst, 32'h0);
    apb(1'h1, 12'h004, 8'h00);
    apb(1'h1, 12'h000, 8'hc0);
    // compare moved ahead before the counter gets there
    apb(1'h1, 12'h040, 8'h10);
    apb(1'h1, 12'h060, 8'h01);
    tk(3);
    ck(nrst, 32'h0);
    apb(1'h1, 12'h040, 8'h04);
    apb(1'h1, 12'h060, 8'h01);
    tk(3);
    ck(nrst, 32'h1);
  endtask : t_wdog
  task t_wrap;
    apb(1'h1, 12'h008, 8'hff);
    apb(1'h1, 12'h004, 8'hff);
    apb(1'h1, 12'h000, 8'h80);
    tk(1);
    apb(1'h1, 12'h000, 8'h00);
    rd(12'h004, 8'h00);
    rd(12'h008, 8'h00);
  endtask : t_wrap
  task t_bad;
    apb(1'h0, 12'h100, 8'h00);
    ck(r, 32'h0);
    ck(se, 1'h1);
  endtask : t_bad
  task results;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_cmp;
    t_tog;
    t_cap;
    t_pwm;
    t_wdog;
    t_wrap;
    t_bad;
    results;
  end
  // far beyond the few hundred apb cycles the tests need
  initial begin
    #100000;
    err_count++;
    results;
  end
endmodule : tb
